// file: core/usc_pkg.sv
// Constants, field layouts and carrier types of the bus engine registers.
//
// Summary of operation
// - Host access to endpoint 0, 1 or 2 sets its flag; gated interrupt.
// - Two-bit bus mode selects regulator, resistors and pin ownership.
// - Bus mode marker bit 7 is firmware read/write, reset clears it.
// - Bus clock enable bit 3 gates the bus clock, resets to zero.
// - Deep suspend bit 4 turns off band-gap and reset; blocked in bus mode.
// - Keyboard-mouse marker bit 5 is firmware read/write, resets to zero.
// - Bit 7 disables temperature adjustment when one, enabled by default.
// - Read-only access bitmap, one bit per endpoint, resets to zero.
// - Access bitmap is refreshed when the access-active signal is issued.
// - Direction bits 1 and 2 pick IN when one, OUT when zero.
// - Bit 0 held low long enough resets data toggles of endpoints 1, 2.
// - Enable map gates endpoints 1 and 2; endpoint 0 always on.
// - Line-state bits 0..2 latch EOP, J and K until firmware clears.
// - Line-state bits 3 and 4 latch SE0 and SE1 noise until cleared.
// - In bus mode only the engine drives the two bus pins.
package usc_pkg;

   // Register indices; the byte address is four times the index.
   localparam logic [7:0] IDX_EP_IRQ_MODE = 8'h21;
   localparam logic [7:0] IDX_CLK_CTRL = 8'h22;
   localparam logic [7:0] IDX_LINE_STATE = 8'h40;
   localparam logic [7:0] IDX_PIPE_CTRL = 8'h41;
   localparam logic [7:0] IDX_STALL_MAP = 8'h43;
   localparam logic [7:0] IDX_ACCESS_MAP = 8'h44;
   localparam logic [7:0] IDX_ENABLE_MAP = 8'h47;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h50;
   localparam logic [7:0] IDX_IRQ_CLEAR = 8'h51;
   localparam logic [7:0] IDX_IRQ_ENABLE = 8'h52;

   // Field positions.
   localparam int unsigned POS_MODE_LO = 4;
   localparam int unsigned POS_BUS_MARK = 7;
   localparam int unsigned POS_CLK_EN = 3;
   localparam int unsigned POS_DEEP_SUSP = 4;
   localparam int unsigned POS_KBM_MARK = 5;
   localparam int unsigned POS_OSC_SEL = 6;
   localparam int unsigned POS_ADJ_DIS = 7;
   localparam int unsigned POS_TOGGLE = 0;
   localparam int unsigned POS_LINE_EVT = 3;

   // Values after reset.
   localparam logic [2:0] RST_PIPE_CTRL = 3'h7;
   localparam logic [2:0] RST_STALL_MAP = 3'h7;
   localparam logic [2:0] RST_ACCESS_MAP = 3'h0;
   localparam logic [2:0] RST_ENABLE_MAP = 3'h7;
   localparam logic [7:0] RST_IRQ_ENABLE = 8'h00;

   // Bus mode encodings.
   localparam logic [1:0] MODE_PLAIN_OFF = 2'h0;
   localparam logic [1:0] MODE_PLAIN_200R = 2'h1;
   localparam logic [1:0] MODE_BUS = 2'h2;
   localparam logic [1:0] MODE_PLAIN_33V = 2'h3;

   // Least low time of the toggle bit, in instruction cycles.
   localparam int unsigned TOGGLE_LOW_INSTR = 10;

   // Events reported by the serial interface engine, one-cycle pulses.
   typedef struct packed {
      logic [2:0] ep_access;
      logic access_active;
      logic eop;
      logic j_state;
      logic k_state;
      logic se0_noise;
      logic se1_noise;
   } usc_sie_evt_t;

   // Pad and analog controls derived from the bus mode.
   typedef struct packed {
      logic regulator_on;
      logic supply_200r;
      logic pullup_1k5;
      logic out_33v;
   } usc_pad_ctrl_t;

   // Clock and power controls.
   typedef struct packed {
      logic bus_clock_en;
      logic bandgap_off;
      logic lvr_disable;
      logic osc_6mhz_sel;
      logic clk_adj_disable;
   } usc_clk_ctrl_t;

endpackage

// file: core/usc_regs.sv
// Control and status register bank of the low-speed bus interface engine.
`timescale 1ns/1ps

module usc_regs
   import usc_pkg::*;
#(
   parameter int unsigned CYC_PER_INSTR = 1
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [9:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Serial interface engine side
   input wire usc_sie_evt_t sie_evt_i,
   input wire logic stack_full_i,
   input wire logic [1:0] sie_pin_drv_i,
   input wire logic sie_pin_oe_i,
   // Bus pins, index 1 is the plus line, index 0 the minus line
   input wire logic [1:0] bus_pin_i,
   output logic [1:0] bus_pin_o,
   output logic [1:0] bus_pin_oe_n_o,
   output logic [1:0] bus_pin_sync_o,
   // Controls
   output usc_pad_ctrl_t pad_ctrl_o,
   output usc_clk_ctrl_t clk_ctrl_o,
   output logic [2:1] ep_dir_in_o,
   output logic [2:0] ep_stall_o,
   output logic [2:0] ep_enable_o,
   output logic [2:1] toggle_reset_o,
   output logic pins_fw_access_o,
   // Interrupt
   output logic irq_o
);

   localparam int unsigned TOGGLE_LOW_CYC = TOGGLE_LOW_INSTR * CYC_PER_INSTR;
   localparam logic [15:0] TOGGLE_LIM = 16'(TOGGLE_LOW_CYC);

   if (CYC_PER_INSTR < 1 || TOGGLE_LOW_CYC > 16'hffff) begin : g_chk
      $error("CYC_PER_INSTR out of range");
   end

   // -----------------------------------------------------------------------
   // State
   // -----------------------------------------------------------------------

   typedef struct packed {
      logic ack;
      logic [31:0] dat;
      logic [2:0] ep_flag;
      logic [1:0] mode;
      logic bus_mark;
      logic clk_en;
      logic deep_susp;
      logic kbm_mark;
      logic osc_sel;
      logic adj_dis;
      logic [4:0] line_state;
      logic [2:0] pipe_ctrl;
      logic [2:0] stall_map;
      logic [2:0] access_map;
      logic [2:0] access_pend;
      logic [2:0] enable_map;
      logic [15:0] toggle_cnt;
      logic toggle_pulse;
      logic [7:0] irq_status;
      logic [7:0] irq_enable;
      logic irq;
      logic [1:0] pin_meta;
      logic [1:0] pin_sync;
      logic [1:0] pin_out;
      logic [1:0] pin_oe_n;
      logic fw_pins;
      usc_pad_ctrl_t pad;
   } usc_state_t;

   usc_state_t s_q;
   usc_state_t s_d;

   logic req;
   logic wr;
   logic [7:0] idx;
   logic [7:0] wdat;
   logic [7:0] rdata;
   logic [7:0] evt_vec;
   logic [4:0] line_evt;
   logic bus_mode;

   // -----------------------------------------------------------------------
   // Next state
   // -----------------------------------------------------------------------

   always_comb begin
      s_d = s_q;
      idx = adr_i[9:2];
      wdat = dat_i[7:0];
      req = cyc_i & stb_i & ~s_q.ack;
      wr = req & we_i & sel_i[0];
      line_evt = {sie_evt_i.se1_noise, sie_evt_i.se0_noise,
                  sie_evt_i.k_state, sie_evt_i.j_state, sie_evt_i.eop};
      evt_vec = {line_evt, sie_evt_i.ep_access};

      // Endpoint access flags: firmware writes, the engine sets on access.
      for (int i = 0; i < 3; i++) begin
         if (wr && idx == IDX_EP_IRQ_MODE) begin
            s_d.ep_flag[i] = wdat[i];
         end
         if (sie_evt_i.ep_access[i]) begin
            s_d.ep_flag[i] = 1'b1;
         end
      end

      if (wr && idx == IDX_EP_IRQ_MODE) begin
         s_d.mode = wdat[POS_MODE_LO +: 2];
         s_d.bus_mark = wdat[POS_BUS_MARK];
      end
      bus_mode = (s_d.mode == MODE_BUS);

      // Clock control; deep suspend can never be held in bus mode.
      if (wr && idx == IDX_CLK_CTRL) begin
         s_d.clk_en = wdat[POS_CLK_EN];
         s_d.deep_susp = wdat[POS_DEEP_SUSP];
         s_d.kbm_mark = wdat[POS_KBM_MARK];
         s_d.osc_sel = wdat[POS_OSC_SEL];
         s_d.adj_dis = wdat[POS_ADJ_DIS];
      end
      if (bus_mode) begin
         s_d.deep_susp = 1'b0;
      end

      // Line-state flags stick until firmware writes them to zero.
      for (int i = 0; i < 5; i++) begin
         if (wr && idx == IDX_LINE_STATE) begin
            s_d.line_state[i] = wdat[i];
         end
         if (line_evt[i]) begin
            s_d.line_state[i] = 1'b1;
         end
      end

      if (wr && idx == IDX_PIPE_CTRL) begin
         s_d.pipe_ctrl = wdat[2:0];
      end
      if (wr && idx == IDX_STALL_MAP) begin
         s_d.stall_map = wdat[2:0];
      end
      if (wr && idx == IDX_ENABLE_MAP) begin
         s_d.enable_map = wdat[2:0];
      end

      // Toggle reset fires once the bit has stayed low for the least time.
      s_d.toggle_pulse = 1'b0;
      if (!s_q.pipe_ctrl[POS_TOGGLE]) begin
         if (s_q.toggle_cnt < TOGGLE_LIM) begin
            s_d.toggle_cnt = s_q.toggle_cnt + 16'h0001;
         end
         if (s_q.toggle_cnt == TOGGLE_LIM - 16'h0001) begin
            s_d.toggle_pulse = 1'b1;
         end
      end else begin
         s_d.toggle_cnt = 16'h0000;
      end

      // Accesses gather until the access-active signal publishes them.
      s_d.access_pend = s_q.access_pend | sie_evt_i.ep_access;
      if (sie_evt_i.access_active) begin
         s_d.access_map = s_d.access_pend;
         s_d.access_pend = 3'h0;
      end

      // Interrupt status: write-one-to-clear, a new event wins.
      if (wr && idx == IDX_IRQ_CLEAR) begin
         s_d.irq_status = s_q.irq_status & ~wdat;
      end
      s_d.irq_status = s_d.irq_status | evt_vec;
      if (wr && idx == IDX_IRQ_ENABLE) begin
         s_d.irq_enable = wdat;
      end
      s_d.irq = (|(s_d.irq_status & s_d.irq_enable)) & ~stack_full_i;

      // Pads follow the bus mode; in bus mode the engine owns the pins.
      s_d.pad.regulator_on = (s_d.mode != MODE_PLAIN_OFF);
      s_d.pad.supply_200r = (s_d.mode == MODE_PLAIN_200R);
      s_d.pad.pullup_1k5 = bus_mode;
      s_d.pad.out_33v = bus_mode | (s_d.mode == MODE_PLAIN_33V);
      s_d.pin_meta = bus_pin_i;
      s_d.pin_sync = s_q.pin_meta;
      s_d.pin_out = bus_mode ? sie_pin_drv_i : 2'h0;
      s_d.pin_oe_n = (bus_mode && sie_pin_oe_i) ? 2'h0 : 2'h3;
      s_d.fw_pins = ~bus_mode;

      // Register read mux; reserved bits and unmapped indices read zero.
      case (idx)
         IDX_EP_IRQ_MODE: rdata = {s_q.bus_mark, 1'b0, s_q.mode, 1'b0,
                                   s_q.ep_flag};
         IDX_CLK_CTRL: rdata = {s_q.adj_dis, s_q.osc_sel, s_q.kbm_mark,
                                s_q.deep_susp, s_q.clk_en, 3'h0};
         IDX_LINE_STATE: rdata = {3'h0, s_q.line_state};
         IDX_PIPE_CTRL: rdata = {5'h00, s_q.pipe_ctrl};
         IDX_STALL_MAP: rdata = {5'h00, s_q.stall_map};
         IDX_ACCESS_MAP: rdata = {5'h00, s_q.access_map};
         IDX_ENABLE_MAP: rdata = {5'h00, s_q.enable_map};
         IDX_IRQ_STATUS: rdata = s_q.irq_status;
         IDX_IRQ_ENABLE: rdata = s_q.irq_enable;
         default: rdata = 8'h00;
      endcase

      s_d.ack = req;
      s_d.dat = (req && !we_i) ? {24'h00_0000, rdata} : 32'h0000_0000;
   end

   // -----------------------------------------------------------------------
   // Registers
   // -----------------------------------------------------------------------

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q <= '0;
         s_q.mode <= MODE_PLAIN_OFF;
         s_q.pipe_ctrl <= RST_PIPE_CTRL;
         s_q.stall_map <= RST_STALL_MAP;
         s_q.access_map <= RST_ACCESS_MAP;
         s_q.enable_map <= RST_ENABLE_MAP;
         s_q.irq_enable <= RST_IRQ_ENABLE;
         s_q.pin_oe_n <= 2'h3;
         s_q.fw_pins <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // -----------------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------------

   assign ack_o = s_q.ack;
   assign dat_o = s_q.dat;
   assign irq_o = s_q.irq;
   assign bus_pin_o = s_q.pin_out;
   assign bus_pin_oe_n_o = s_q.pin_oe_n;
   assign bus_pin_sync_o = s_q.pin_sync;
   assign pad_ctrl_o = s_q.pad;
   assign clk_ctrl_o.bus_clock_en = s_q.clk_en;
   assign clk_ctrl_o.bandgap_off = s_q.deep_susp;
   assign clk_ctrl_o.lvr_disable = s_q.deep_susp;
   assign clk_ctrl_o.osc_6mhz_sel = s_q.osc_sel;
   assign clk_ctrl_o.clk_adj_disable = s_q.adj_dis;
   assign ep_dir_in_o = s_q.pipe_ctrl[2:1];
   assign ep_stall_o = s_q.stall_map;
   // Endpoint 0 is outside the enable map's control.
   assign ep_enable_o = {s_q.enable_map[2:1], 1'b1};
   assign toggle_reset_o = {2{s_q.toggle_pulse}};
   assign pins_fw_access_o = s_q.fw_pins;

endmodule

// file: testbench/usc_sie_model.sv
// Engine model: event pulses and pin data facing the register bank.
`timescale 1ns/1ps
module usc_sie_model
   import usc_pkg::*;
(
   // Clock and commands
   input wire logic clk_i,
   input wire usc_sie_evt_t fire_i,
   input wire logic drive_i,
   // Engine outputs
   output usc_sie_evt_t evt_o,
   output logic [1:0] drv_o,
   output logic oe_o
);
   // Pin data changes every cycle so a stale value is never mistaken.
   always @(posedge clk_i) begin
      evt_o <= fire_i;
      drv_o <= (drv_o === 2'h1) ? 2'h2 : 2'h1;
      oe_o <= drive_i;
   end
endmodule

// file: testbench/usc_regs_props.sv
// Port assertions of the register bank.
`timescale 1ns/1ps
module usc_regs_props
   import usc_pkg::*;
(
   // Clock, reset and bus
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic ack_o,
   // Engine, pins and controls
   input wire logic stack_full_i,
   input wire logic [1:0] sie_pin_drv_i,
   input wire logic sie_pin_oe_i,
   input wire logic [1:0] bus_pin_o,
   input wire logic [1:0] bus_pin_oe_n_o,
   input wire usc_pad_ctrl_t pad_ctrl_o,
   input wire usc_clk_ctrl_t clk_ctrl_o,
   input wire logic [2:1] ep_dir_in_o,
   input wire logic [2:0] ep_stall_o,
   input wire logic [2:0] ep_enable_o,
   input wire logic [2:1] toggle_reset_o,
   input wire logic irq_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_ack_pulse: assert property (ack_o |=> !ack_o)
      else $error("ack too long");
   a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("request not answered");
   a_irq_stack: assert property (irq_o |-> !$past(stack_full_i))
      else $error("irq with stack full");
   a_pin_drive: assert property (
      bus_pin_oe_n_o != 2'h3 |-> $past(sie_pin_oe_i) && pad_ctrl_o.pullup_1k5
      && bus_pin_o == $past(sie_pin_drv_i)) else $error("bad pin drive");
   a_susp_block: assert property (
      pad_ctrl_o.pullup_1k5 |-> !clk_ctrl_o.bandgap_off
      && clk_ctrl_o.lvr_disable == clk_ctrl_o.bandgap_off)
      else $error("suspend in bus mode");
   a_toggle_pulse: assert property (
      toggle_reset_o != 2'h0 |-> toggle_reset_o == 2'h3 ##1
      toggle_reset_o == 2'h0) else $error("bad toggle pulse");
   a_reset_maps: assert property (
      $fell(rst_i) |-> ep_stall_o == 3'h7 && ep_enable_o == 3'h7
      && ep_dir_in_o == 2'h3) else $error("bad map reset");
   a_ep0_on: assert property (ep_enable_o[0])
      else $error("endpoint zero off");
   c_toggle: cover property (toggle_reset_o == 2'h3);
   c_irq: cover property (irq_o);
   c_drive: cover property (bus_pin_oe_n_o == 2'h0);
endmodule

bind usc_regs usc_regs_props u_props (.clk_i, .rst_i, .cyc_i, .stb_i,
   .ack_o, .stack_full_i, .sie_pin_drv_i, .sie_pin_oe_i, .bus_pin_o,
   .bus_pin_oe_n_o, .pad_ctrl_o, .clk_ctrl_o, .ep_dir_in_o, .ep_stall_o,
   .ep_enable_o, .toggle_reset_o, .irq_o);

// file: testbench/usc_regs_bench.sv
// Self-checking bench of the register bank and its engine model.
`timescale 1ns/1ps
module usc_regs_bench
   import usc_pkg::*;
;
   logic clk_i = 1'h0, rst_i = 1'h1, cyc_i = 1'h0, stb_i = 1'h0;
   logic we_i = 1'h0, stack_full_i = 1'h0, drive = 1'h0;
   logic [3:0] sel_i = 4'h0;
   logic [9:0] adr_i = 10'h000;
   logic [31:0] dat_i = 32'h0000_0000, dat_o;
   logic ack_o, sie_pin_oe_i, pins_fw_access_o, irq_o;
   logic [1:0] bus_pin_i = 2'h0, sie_pin_drv_i, bus_pin_o;
   logic [1:0] bus_pin_oe_n_o, bus_pin_sync_o;
   logic [2:1] ep_dir_in_o, toggle_reset_o;
   logic [2:0] ep_stall_o, ep_enable_o;
   usc_sie_evt_t fire = '0, sie_evt_i;
   usc_pad_ctrl_t pad_ctrl_o;
   usc_clk_ctrl_t clk_ctrl_o;
   logic [7:0] exp_q[$];
   logic [15:0] rt[9] = '{16'h2100, 16'h2200, 16'h4000, 16'h4107,
      16'h4307, 16'h4400, 16'h4707, 16'h5200, 16'h6000};
   logic [3:0] pad_t[4] = '{4'h0, 4'hc, 4'hb, 4'h9};
   int fail_count = 0, cmp_count = 0, cycles = 0, n;
   int seed = 32'h24ac;
   logic [7:0] d;

   usc_regs #(.CYC_PER_INSTR(1)) u_dut (.clk_i, .rst_i, .cyc_i, .stb_i,
      .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .sie_evt_i,
      .stack_full_i, .sie_pin_drv_i, .sie_pin_oe_i, .bus_pin_i, .bus_pin_o,
      .bus_pin_oe_n_o, .bus_pin_sync_o, .pad_ctrl_o, .clk_ctrl_o,
      .ep_dir_in_o, .ep_stall_o, .ep_enable_o, .toggle_reset_o,
      .pins_fw_access_o, .irq_o);
   usc_sie_model u_sie (.clk_i, .fire_i(fire), .drive_i(drive),
      .evt_o(sie_evt_i), .drv_o(sie_pin_drv_i), .oe_o(sie_pin_oe_i));

   initial forever #2.5 clk_i = ~clk_i;

   task automatic check(input string what, input logic [7:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] idx, v);
      cyc_i <= 1'h1;
      stb_i <= 1'h1;
      we_i <= w;
      sel_i <= 4'h1;
      adr_i <= {idx, 2'h0};
      dat_i <= {24'h00_0000, v};
      @(posedge clk_i);
      while (ack_o !== 1'h1) begin
         @(posedge clk_i);
      end
      cyc_i <= 1'h0;
      stb_i <= 1'h0;
      @(posedge clk_i);
   endtask
   task automatic wr(input logic [7:0] idx, v);
      wb(1'h1, idx, v);
   endtask
   task automatic rd(input logic [7:0] idx, v);
      exp_q.push_back(v);
      wb(1'h0, idx, 8'h00);
   endtask
   task automatic pulse(input usc_sie_evt_t e);
      fire <= e;
      @(posedge clk_i);
      fire <= '0;
   endtask
   task automatic watch(input int c, output int p);
      p = 0;
      repeat (c) begin
         @(posedge clk_i);
         p += int'(toggle_reset_o != 2'h0);
      end
   endtask
   task automatic test_done();
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Each read answer is compared with the oldest expected value.
   always @(posedge clk_i) begin
      if (ack_o === 1'h1 && cyc_i === 1'h1 && we_i === 1'h0)
         check("read", dat_o[7:0], exp_q.pop_front());
   end
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 3000) begin
         fail_count++;
         test_done();
      end
   end

   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'h0;
      @(posedge clk_i);
      foreach (rt[i]) rd(rt[i][15:8], rt[i][7:0]);
      $display("reset test done");
      for (int i = 0; i < 4; i++) begin
         d = 8'($random(seed));
         wr(IDX_CLK_CTRL, d);
         rd(IDX_CLK_CTRL, d & 8'hf8);
         check("clk", clk_ctrl_o, {d[3], d[4], d[4], d[6], d[7]});
         wr(IDX_STALL_MAP, d);
         wr(IDX_ENABLE_MAP, d);
         wr(IDX_PIPE_CTRL, d | 8'h01);
         wr(IDX_ACCESS_MAP, d);
         rd(IDX_ACCESS_MAP, 8'h00);
         check("stall", ep_stall_o, d[2:0]);
         check("enable", ep_enable_o, {d[2:1], 1'h1});
         check("dir", ep_dir_in_o, d[2:1]);
      end
      $display("register test done");
      rst_i <= 1'h1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'h0;
      @(posedge clk_i);
      check("stall rst", ep_stall_o, 8'h07);
      check("enable rst", ep_enable_o, 8'h07);
      check("dir rst", ep_dir_in_o, 8'h03);
      rd(IDX_CLK_CTRL, 8'h00);
      $display("mid reset test done");
      drive <= 1'h1;
      for (int m = 0; m < 4; m++) begin
         wr(IDX_EP_IRQ_MODE, 8'h80 | 8'(m << 4));
         wr(IDX_CLK_CTRL, 8'h10);
         bus_pin_i <= 2'($random(seed));
         rd(IDX_EP_IRQ_MODE, 8'h80 | 8'(m << 4));
         rd(IDX_CLK_CTRL, m == 2 ? 8'h00 : 8'h10);
         check("pad", pad_ctrl_o, pad_t[m]);
         check("pin in", bus_pin_sync_o, bus_pin_i);
         check("fw pins", pins_fw_access_o, m != 2);
         check("oe", bus_pin_oe_n_o, m == 2 ? 2'h0 : 2'h3);
         wr(IDX_CLK_CTRL, 8'h00);
      end
      drive <= 1'h0;
      $display("mode test done");
      wr(IDX_EP_IRQ_MODE, 8'h00);
      wr(IDX_IRQ_ENABLE, 8'hff);
      pulse('{ep_access: 3'h5, default: 1'h1});
      @(posedge clk_i);
      rd(IDX_LINE_STATE, 8'h1f);
      rd(IDX_ACCESS_MAP, 8'h05);
      rd(IDX_EP_IRQ_MODE, 8'h05);
      rd(IDX_IRQ_STATUS, 8'hfd);
      check("irq", irq_o, 1'h1);
      stack_full_i <= 1'h1;
      repeat (2) @(posedge clk_i);
      check("irq masked", irq_o, 1'h0);
      stack_full_i <= 1'h0;
      pulse('{ep_access: 3'h2, default: 1'h0});
      @(posedge clk_i);
      rd(IDX_ACCESS_MAP, 8'h05);
      pulse('{access_active: 1'h1, default: 1'h0});
      @(posedge clk_i);
      rd(IDX_ACCESS_MAP, 8'h02);
      wr(IDX_EP_IRQ_MODE, 8'h00);
      pulse('{eop: 1'h1, default: 1'h0});
      wr(IDX_LINE_STATE, 8'h00);
      wr(IDX_IRQ_CLEAR, 8'hff);
      check("irq cleared", irq_o, 1'h0);
      rd(IDX_LINE_STATE, 8'h01);
      rd(IDX_EP_IRQ_MODE, 8'h00);
      $display("event test done");
      wr(IDX_PIPE_CTRL, 8'h06);
      wr(IDX_PIPE_CTRL, 8'h07);
      watch(20, n);
      check("short low", 8'(n), 8'h00);
      wr(IDX_PIPE_CTRL, 8'h06);
      watch(8, n);
      check("early pulse", 8'(n), 8'h00);
      watch(20, n);
      check("pulses", 8'(n), 8'h01);
      $display("toggle test done");
      test_done();
   end
endmodule
